// *** shp_pkg.sv ***
package shp_pkg;

  // ----------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IFACE_CONFIG = 8'h1a;  // Serial interface settings.
  localparam logic [7:0] ADDR_RATE = 8'h1d;  // Output rate selector.
  localparam logic [7:0] ADDR_FILTER = 8'h1f;  // Smoothing filter setting.
  localparam logic [7:0] ADDR_TRIM_FIRST = 8'h30;  // First trim coefficient byte.
  localparam logic [7:0] ADDR_TRIM_LAST = 8'h57;  // Last trim coefficient byte.
  localparam logic [7:0] ADDR_CMD = 8'h7e;  // Command entry.

  // ----------------------------------------------------------------
  // Field positions, reset values and codes.
  // ----------------------------------------------------------------
  localparam int RATE_MSB = 4;  // Rate selector occupies bits 4..0.
  localparam int FILTER_MSB = 3;  // Filter code occupies bits 3..1.
  localparam int FILTER_LSB = 1;  // Low bit of the filter code.
  localparam int THREE_WIRE_BIT = 0;  // Three-wire select bit.
  localparam int SPI_RW_BIT = 7;  // Read/write flag in the control byte.
  localparam logic [4:0] RATE_MAX = 5'h11;  // Highest rate selector.
  localparam logic [4:0] RATE_RESET = 5'h00;  // Rate selector after reset.
  localparam logic [2:0] FILTER_RESET = 3'h0;  // Filter code after reset.
  localparam logic THREE_WIRE_RESET = 1'b0;  // Four-wire after reset.
  localparam logic [7:0] CMD_FLUSH = 8'hb0;  // Discard buffered samples.
  localparam logic [7:0] CMD_SOFT_RESET = 8'hb6;  // Restore defaults.
  localparam logic [7:0] CMD_READ_VALUE = 8'h00;  // Command entry always reads this.
  localparam logic [5:0] I2C_ADDR_UPPER = 6'h3b;  // Fixed upper six address bits.
  localparam logic [3:0] PIN_SYNC_RESET = 4'he;  // Idle pin levels: sck, sdi, cs high.

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int BASE_PERIOD_US = 5000;  // Sampling period at selector zero.
  localparam int CLK_FREQ_MHZ = 200;  // Logic clock rate.
  localparam int BASE_CYCLES = BASE_PERIOD_US * CLK_FREQ_MHZ;  // Clocks per base period.

  // ----------------------------------------------------------------
  // State types.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_REG, I2C_WDATA, I2C_READ} shp_i2c_state_t;
  typedef enum logic [1:0] {SPI_CTRL, SPI_WDATA, SPI_DUMMY, SPI_RDATA} shp_spi_phase_t;

endpackage

// *** shp_host_port.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Rate selector bits 4..0, saturating at 17.
// - Sample period is base period times two^selector.
// - Filter code bits 3..1; zero bypasses, else 2^n-1.
// - Command register always reads back zero.
// - Code 0xb0 flushes the sample buffer only.
// - Code 0xb6 restores every setting to default.
// - Slave only on I2C and SPI modes 00/11.
// - Writes carry address and data pairs.
// - Reads auto-increment from one start address.
// - Chip select high means I2C, low means SPI.
// - One low chip select locks SPI until power-on.
// - Upper six address bits fixed, low bit from pin.
// - Address 0x76 with pin low, 0x77 high.
// - I2C data pin only pulled low, else released.
// - SPI control byte: read flag plus seven bits.
// - SPI read inserts one dummy byte first.
// - Three-wire bit moves SPI output onto data pin.
module shp_host_port #(
  parameter int BASE_CYCLES = shp_pkg::BASE_CYCLES,  // Clocks per base period.
  parameter logic [7:0] TRIM_SEED = 8'h5a  // Arbitrary stand-in for trim contents.
) (
  input wire logic clock,  // Logic clock, 200 MHz.
  input wire logic rst_b,  // Power-on reset, synchronous, active low.
  input wire logic sck_pin,  // Serial clock from the host.
  input wire logic sdi_in,  // Data pin level.
  output logic sdi_out,  // Data pin drive value.
  output logic sdi_oe,  // Data pin drive enable.
  input wire logic select_low_pin,  // Chip select, active low.
  input wire logic addr_lsb_dout_in,  // Address bit / SPI output pin level.
  output logic addr_lsb_dout_out,  // SPI output drive value.
  output logic addr_lsb_dout_oe,  // SPI output drive enable.
  output logic [4:0] rate_sel,  // Active rate selector.
  output logic sample_tick,  // One-cycle pulse per sampling period.
  output logic [2:0] filter_code,  // Active filter code.
  output logic [6:0] iir_coef,  // Filter coefficient, zero in bypass.
  output logic three_wire_sel,  // SPI three-wire mode.
  output logic spi_mode,  // High once SPI has been locked in.
  output logic fifo_flush,  // One-cycle flush request.
  output logic soft_reset  // One-cycle soft reset pulse.
);

  // ----------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------
  localparam int BASE_W = (BASE_CYCLES > 1) ? $clog2(BASE_CYCLES) : 1;  // Counter width.

  if (BASE_CYCLES < 2) begin : g_bad_base
    $error("BASE_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg;  // First stage, read only by the second.
  logic [3:0] sync2_reg;  // Second stage, safe to use.
  logic [3:0] prev_reg;  // Previous safe level, for edge detection.

  // Two flip-flops on every pin, then one more for edges.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync1_reg <= shp_pkg::PIN_SYNC_RESET;
      sync2_reg <= shp_pkg::PIN_SYNC_RESET;
      prev_reg <= shp_pkg::PIN_SYNC_RESET;
    end else begin
      sync1_reg <= {sck_pin, sdi_in, select_low_pin, addr_lsb_dout_in};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic sck_s, sdi_s, cs_s, ald_s;  // Synchronised pin levels.
  logic sck_rise, sck_fall, sdi_rise, sdi_fall, cs_fall;  // Edge pulses.
  assign {sck_s, sdi_s, cs_s, ald_s} = sync2_reg;
  assign sck_rise = sck_s & ~prev_reg[3];
  assign sck_fall = ~sck_s & prev_reg[3];
  assign sdi_rise = sdi_s & ~prev_reg[2];
  assign sdi_fall = ~sdi_s & prev_reg[2];
  assign cs_fall = ~cs_s & prev_reg[1];

  // ----------------------------------------------------------------
  // Protocol selection.
  // ----------------------------------------------------------------
  logic spi_lock_reg;  // Set by the first low chip select.
  logic spi_sel;  // SPI frame in progress.
  logic i2c_act;  // I2C slave enabled.

  // Only power-on reset clears the lock; soft reset leaves it.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      spi_lock_reg <= 1'b0;
    end else if (!cs_s) begin
      spi_lock_reg <= 1'b1;
    end
  end

  assign i2c_act = ~spi_lock_reg;
  assign spi_sel = spi_lock_reg & ~cs_s;

  // ----------------------------------------------------------------
  // Register storage and read mux.
  // ----------------------------------------------------------------
  logic [4:0] rate_reg;  // Rate selector.
  logic [2:0] filter_reg;  // Filter code.
  logic [6:0] coef_reg;  // Decoded filter coefficient.
  logic three_wire_reg;  // Three-wire select.
  logic flush_reg;  // Flush pulse.
  logic soft_rst_reg;  // Soft reset pulse.
  logic wr_en;  // Register write strobe.
  logic [7:0] wr_addr, wr_data;  // Register write address and data.

  // Returns the byte seen by a read at the given address.
  function automatic logic [7:0] rd_data(input logic [7:0] addr);
    logic [7:0] val;
    val = 8'h00;
    if (addr == shp_pkg::ADDR_IFACE_CONFIG) begin
      val[shp_pkg::THREE_WIRE_BIT] = three_wire_reg;
    end else if (addr == shp_pkg::ADDR_RATE) begin
      val[shp_pkg::RATE_MSB:0] = rate_reg;
    end else if (addr == shp_pkg::ADDR_FILTER) begin
      val[shp_pkg::FILTER_MSB:shp_pkg::FILTER_LSB] = filter_reg;
    end else if (addr >= shp_pkg::ADDR_TRIM_FIRST && addr <= shp_pkg::ADDR_TRIM_LAST) begin
      val = TRIM_SEED ^ addr;
    end else if (addr == shp_pkg::ADDR_CMD) begin
      val = shp_pkg::CMD_READ_VALUE;
    end
    return val;
  endfunction

  // Configuration registers; soft reset restores them a cycle later.
  always_ff @(posedge clock) begin
    if (!rst_b || soft_rst_reg) begin
      rate_reg <= shp_pkg::RATE_RESET;
      filter_reg <= shp_pkg::FILTER_RESET;
      coef_reg <= 7'h00;
      three_wire_reg <= shp_pkg::THREE_WIRE_RESET;
    end else if (wr_en) begin
      if (wr_addr == shp_pkg::ADDR_RATE) begin
        // Selectors above the top code saturate.
        rate_reg <= (wr_data[4:0] > shp_pkg::RATE_MAX) ? shp_pkg::RATE_MAX
                                                       : wr_data[4:0];
      end else if (wr_addr == shp_pkg::ADDR_FILTER) begin
        filter_reg <= wr_data[shp_pkg::FILTER_MSB:shp_pkg::FILTER_LSB];
        coef_reg <= 7'((8'h01 << wr_data[3:1]) - 8'h01);
      end else if (wr_addr == shp_pkg::ADDR_IFACE_CONFIG) begin
        three_wire_reg <= wr_data[shp_pkg::THREE_WIRE_BIT];
      end
    end
  end

  // Command decode; pulses appear the cycle after the write.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flush_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
    end else begin
      flush_reg <= wr_en && wr_addr == shp_pkg::ADDR_CMD
                   && wr_data == shp_pkg::CMD_FLUSH;
      // Any other code, including zero, is ignored.
      soft_rst_reg <= wr_en && wr_addr == shp_pkg::ADDR_CMD
                      && wr_data == shp_pkg::CMD_SOFT_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Sampling period generator.
  // ----------------------------------------------------------------
  logic [BASE_W-1:0] base_cnt_reg;  // Counts clocks in a base period.
  logic [16:0] div_cnt_reg;  // Counts base periods.
  logic tick_reg;  // Sample tick.
  logic [16:0] div_last;  // Last base period of a sample period.

  assign div_last = 17'((18'h00001 << rate_reg) - 18'h00001);

  // Base period multiplied by two to the selector.
  always_ff @(posedge clock) begin
    if (!rst_b || soft_rst_reg) begin
      base_cnt_reg <= '0;
      div_cnt_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (base_cnt_reg == BASE_W'(BASE_CYCLES - 1)) begin
        base_cnt_reg <= '0;
        if (div_cnt_reg >= div_last) begin
          div_cnt_reg <= 17'h00000;
          tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 17'h00001;
        end
      end else begin
        base_cnt_reg <= base_cnt_reg + BASE_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // I2C slave.
  // ----------------------------------------------------------------
  shp_pkg::shp_i2c_state_t i2c_state_reg;  // Byte role in the transfer.
  logic [3:0] i2c_cnt_reg;  // Bit count; 8 ends a byte, 9 is the ack bit.
  logic [7:0] i2c_shift_reg;  // Received byte.
  logic [7:0] i2c_tx_reg;  // Byte being returned.
  logic [7:0] i2c_ptr_reg;  // Register address pointer.
  logic sda_low_reg;  // Pull the data pin low.
  logic i2c_start, i2c_stop, i2c_wr;  // Conditions and write strobe.

  assign i2c_start = i2c_act & sck_s & sdi_fall;
  assign i2c_stop = i2c_act & sck_s & sdi_rise;
  assign i2c_wr = i2c_act & sck_fall & i2c_cnt_reg == 4'h8 & i2c_state_reg == shp_pkg::I2C_WDATA;

  // Byte engine: sample on rising clock, drive on falling clock.
  always_ff @(posedge clock) begin
    if (!rst_b || i2c_stop || !i2c_act) begin
      i2c_state_reg <= shp_pkg::I2C_IDLE;
      i2c_cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
    end else if (i2c_start) begin
      i2c_state_reg <= shp_pkg::I2C_ADDR;
      i2c_cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
    end else if (i2c_state_reg != shp_pkg::I2C_IDLE && sck_rise) begin
      if (i2c_cnt_reg < 4'h8) begin
        i2c_shift_reg <= {i2c_shift_reg[6:0], sdi_s};
        i2c_cnt_reg <= i2c_cnt_reg + 4'h1;
      end else if (i2c_state_reg == shp_pkg::I2C_READ && sdi_s) begin
        i2c_state_reg <= shp_pkg::I2C_IDLE;  // Host declined more data.
      end
    end else if (i2c_state_reg != shp_pkg::I2C_IDLE && sck_fall) begin
      if (i2c_cnt_reg == 4'h8) begin
        i2c_cnt_reg <= 4'h9;
        sda_low_reg <= 1'b1;
        case (i2c_state_reg)
          shp_pkg::I2C_ADDR: begin
            if (i2c_shift_reg[7:1] != {shp_pkg::I2C_ADDR_UPPER, ald_s}) begin
              i2c_state_reg <= shp_pkg::I2C_IDLE;
              sda_low_reg <= 1'b0;
            end else if (i2c_shift_reg[0]) begin
              i2c_state_reg <= shp_pkg::I2C_READ;
            end else begin
              i2c_state_reg <= shp_pkg::I2C_REG;
            end
          end
          shp_pkg::I2C_REG: begin
            i2c_ptr_reg <= i2c_shift_reg;
            i2c_state_reg <= shp_pkg::I2C_WDATA;
          end
          shp_pkg::I2C_WDATA: begin
            i2c_state_reg <= shp_pkg::I2C_REG;
          end
          default: begin
            sda_low_reg <= 1'b0;  // Release for the host's acknowledge.
          end
        endcase
      end else if (i2c_cnt_reg == 4'h9) begin
        i2c_cnt_reg <= 4'h0;
        sda_low_reg <= 1'b0;
        if (i2c_state_reg == shp_pkg::I2C_READ) begin
          i2c_tx_reg <= rd_data(i2c_ptr_reg);
          sda_low_reg <= rd_data(i2c_ptr_reg) < 8'h80;
          i2c_ptr_reg <= i2c_ptr_reg + 8'h01;
        end
      end else if (i2c_state_reg == shp_pkg::I2C_READ && i2c_cnt_reg != 4'h0) begin
        i2c_tx_reg <= {i2c_tx_reg[6:0], 1'b0};
        sda_low_reg <= ~i2c_tx_reg[6];
      end
    end
  end

  // ----------------------------------------------------------------
  // SPI slave.
  // ----------------------------------------------------------------
  shp_pkg::shp_spi_phase_t spi_phase_reg;  // Role of the current byte.
  logic [2:0] spi_cnt_reg;  // Bits received in the current byte.
  logic [6:0] spi_shift_reg;  // Bits received so far.
  logic [7:0] spi_tx_reg;  // Byte being returned.
  logic [7:0] spi_ptr_reg;  // Register address pointer.
  logic spi_dout_reg;  // Output bit.
  logic [7:0] spi_byte;  // Completed byte.
  logic spi_done, spi_wr, spi_reading;  // Byte done, write strobe, read phase.

  assign spi_byte = {spi_shift_reg, sdi_s};
  assign spi_done = spi_sel & sck_rise & spi_cnt_reg == 3'h7;
  assign spi_wr = spi_done & spi_phase_reg == shp_pkg::SPI_WDATA;
  assign spi_reading = spi_phase_reg == shp_pkg::SPI_DUMMY || spi_phase_reg == shp_pkg::SPI_RDATA;

  // Sample on rising clock in both modes; level before the first
  // edge does not matter, which serves modes 00 and 11 alike.
  always_ff @(posedge clock) begin
    if (!rst_b || cs_s) begin
      spi_phase_reg <= shp_pkg::SPI_CTRL;
      spi_cnt_reg <= 3'h0;
      spi_tx_reg <= 8'h00;
    end else if (sck_rise) begin
      spi_shift_reg <= spi_byte[6:0];
      spi_cnt_reg <= spi_cnt_reg + 3'h1;
      if (spi_done) begin
        case (spi_phase_reg)
          shp_pkg::SPI_CTRL: begin
            spi_ptr_reg <= {1'b0, spi_byte[6:0]};
            spi_phase_reg <= spi_byte[shp_pkg::SPI_RW_BIT] ? shp_pkg::SPI_DUMMY
                                                           : shp_pkg::SPI_WDATA;
          end
          shp_pkg::SPI_WDATA: begin
            spi_phase_reg <= shp_pkg::SPI_CTRL;
          end
          default: begin
            // The dummy byte ends before the first data byte loads.
            spi_tx_reg <= rd_data(spi_ptr_reg);
            spi_ptr_reg <= spi_ptr_reg + 8'h01;
            spi_phase_reg <= shp_pkg::SPI_RDATA;
          end
        endcase
      end
    end
  end

  // Output bit changes on falling clock and at frame start.
  always_ff @(posedge clock) begin
    if (!rst_b || cs_fall) begin
      spi_dout_reg <= 1'b0;
    end else if (spi_sel && sck_fall) begin
      spi_dout_reg <= spi_tx_reg[~spi_cnt_reg];
    end
  end

  // ----------------------------------------------------------------
  // Shared write port and pin drivers.
  // ----------------------------------------------------------------
  assign wr_en = i2c_wr | spi_wr;
  assign wr_addr = i2c_act ? i2c_ptr_reg : spi_ptr_reg;
  assign wr_data = i2c_act ? i2c_shift_reg : spi_byte;

  // I2C only ever pulls low; three-wire SPI drives during reads.
  assign sdi_out = spi_lock_reg & spi_dout_reg;
  assign sdi_oe = (i2c_act & sda_low_reg)
                  | (spi_sel & three_wire_reg & spi_reading);
  assign addr_lsb_dout_out = spi_dout_reg;
  assign addr_lsb_dout_oe = spi_sel & ~three_wire_reg;

  assign rate_sel = rate_reg;
  assign sample_tick = tick_reg;
  assign filter_code = filter_reg;
  assign iir_coef = coef_reg;
  assign three_wire_sel = three_wire_reg;
  assign spi_mode = spi_lock_reg;
  assign fifo_flush = flush_reg;
  assign soft_reset = soft_rst_reg;

endmodule

// *** shp_host_port_monitor.sv ***
`timescale 1ns/1ps
// Pin-level checker for the host port.
module shp_host_port_monitor #(
  parameter int BASE_CYCLES = 20  // Clocks per base period.
) (
  input wire logic clock,  // Logic clock.
  input wire logic rst_b,  // Reset, active low.
  input wire logic sdi_out,  // Data drive value.
  input wire logic sdi_oe,  // Data drive enable.
  input wire logic select_low_pin,  // Chip select.
  input wire logic addr_lsb_dout_oe,  // Output drive enable.
  input wire logic [4:0] rate_sel,  // Rate selector.
  input wire logic sample_tick,  // Period pulse.
  input wire logic [2:0] filter_code,  // Filter code.
  input wire logic [6:0] iir_coef,  // Coefficient.
  input wire logic three_wire_sel,  // Three-wire mode.
  input wire logic spi_mode,  // SPI lock.
  input wire logic fifo_flush,  // Flush pulse.
  input wire logic soft_reset  // Soft reset pulse.
);
  int cnt_reg;  // Cycles since the last tick.
  logic seen_reg;  // A tick was seen at the current rate.
  logic [4:0] rate_prev_reg;  // Rate one cycle ago.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Period measurement restarts whenever the rate changes or a soft reset pulses.
  always_ff @(posedge clock) begin
    rate_prev_reg <= rate_sel;
    cnt_reg <= sample_tick ? 0 : cnt_reg + 1;
    if (!rst_b || soft_reset || rate_sel != rate_prev_reg) begin
      seen_reg <= 1'b0;
    end else if (sample_tick) begin
      seen_reg <= 1'b1;
    end
  end
  property p_rate_sat; rate_sel <= 5'h11; endproperty
  a_rate_sat: assert property (p_rate_sat) else $error("rate above 17");
  property p_tick; sample_tick && seen_reg |-> cnt_reg == (BASE_CYCLES << rate_prev_reg) - 1;
  endproperty
  a_tick: assert property (p_tick) else $error("bad sample period");
  property p_coef; filter_code == $past(filter_code) |-> iir_coef == (7'h1 << filter_code) - 7'h1;
  endproperty
  a_coef: assert property (p_coef) else $error("bad coefficient");
  property p_flush; fifo_flush |=> !fifo_flush && $stable(rate_sel) && $stable(filter_code);
  endproperty
  a_flush: assert property (p_flush) else $error("flush disturbed settings");
  property p_soft; soft_reset |=> !soft_reset ##1 rate_sel == 5'h00 && filter_code == 3'h0
    && !three_wire_sel && spi_mode == $past(spi_mode, 2); endproperty
  a_soft: assert property (p_soft) else $error("soft reset left settings");
  property p_lock; spi_mode |=> spi_mode; endproperty
  a_lock: assert property (p_lock) else $error("spi lock lost");
  property p_i2c_hold; select_low_pin [*6] ##0 !spi_mode |=> !spi_mode; endproperty
  a_i2c_hold: assert property (p_i2c_hold) else $error("spi lock without select");
  property p_pull_low; !spi_mode && sdi_oe |-> !sdi_out; endproperty
  a_pull_low: assert property (p_pull_low) else $error("i2c drove high");
  property p_three; three_wire_sel [*3] |-> !addr_lsb_dout_oe; endproperty
  a_three: assert property (p_three) else $error("output pin driven in three-wire");
  property p_four; spi_mode && !three_wire_sel && !$past(three_wire_sel) |-> !sdi_oe; endproperty
  a_four: assert property (p_four) else $error("data pin driven in four-wire");
endmodule
bind shp_host_port shp_host_port_monitor #(.BASE_CYCLES(BASE_CYCLES)) mon_u (
  .clock(clock), .rst_b(rst_b), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
  .select_low_pin(select_low_pin), .addr_lsb_dout_oe(addr_lsb_dout_oe),
  .rate_sel(rate_sel), .sample_tick(sample_tick), .filter_code(filter_code),
  .iir_coef(iir_coef), .three_wire_sel(three_wire_sel), .spi_mode(spi_mode),
  .fifo_flush(fifo_flush), .soft_reset(soft_reset));

// *** shp_host_model.sv ***
`timescale 1ns/1ps
// Host master on the serial pins; the clock aligns frame starts and records the last driven level.
module shp_host_model (
  input wire logic clock,  // Logic clock.
  input wire logic sdi_oe,  // Device drive enable.
  input wire logic sdi_out,  // Device drive value.
  input wire logic dout_w,  // Output pin level.
  output logic sck,  // Serial clock.
  output logic sel_b,  // Chip select, active low.
  output logic sdi_w  // Resolved data pin.
);
  localparam time HALF = 80ns;  // Half of the 160 ns link period.
  logic hv = 1'b1;  // Host drive value.
  logic hrel = 1'b1;  // Host has released the data pin.
  logic i2c = 1'b1;  // Pull-up fitted in I2C use.
  logic three = 1'b0;  // Read data comes back on the data pin.
  logic last = 1'b1;  // Last driven level.
  initial begin
    sck = 1'b1;
    sel_b = 1'b1;  // Select high through power-on keeps I2C usable.
  end
  // A released pin floats high in I2C, else shows the inverse of its last level.
  assign sdi_w = sdi_oe ? sdi_out : (!hrel ? hv : (i2c ? 1'b1 : ~last));
  always @(posedge clock) begin
    if (sdi_oe || !hrel) begin
      last <= sdi_w;
    end
  end
  // Clock idles at the given level while select falls.
  task automatic spi_begin(input logic idle);
    @(posedge clock);
    #1;
    i2c = 1'b0;
    hrel = 1'b0;
    sck = idle;
    #HALF;
    sel_b = 1'b0;
    #HALF;
  endtask
  task automatic spi_end(input logic idle);
    sck = idle;
    #HALF;
    sel_b = 1'b1;
  endtask
  // One byte MSB first, shifted on the fall and taken on the rise.
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      hv = tx[i];
      #HALF;
      sck = 1'b1;
      rx[i] = three ? sdi_w : dout_w;
      #HALF;
    end
  endtask
  // Start: data falls while the clock is high.
  task automatic i2c_start();
    @(posedge clock);
    #1;
    i2c = 1'b1;
    hrel = 1'b0;
    hv = 1'b1;
    sck = 1'b1;
    #HALF;
    hv = 1'b0;
    #HALF;
    sck = 1'b0;
  endtask
  task automatic i2c_stop();
    hv = 1'b0;
    #HALF;
    sck = 1'b1;
    #HALF;
    hv = 1'b1;
    #HALF;
  endtask
  // Eight data bits, then the pin is released for the acknowledge.
  task automatic i2c_byte(input logic [7:0] tx, output logic ack);
    logic [8:0] sh;
    sh = {tx, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      hrel = (i == 0);
      hv = sh[i];
      #HALF;
      sck = 1'b1;
      ack = sdi_w;
      #HALF;
      sck = 1'b0;
    end
    hrel = 1'b0;
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam int BASE = 20;  // Shortened base period.
  localparam logic [7:0] SEED = 8'h3c;  // Arbitrary trim stand-in.
  logic clock = 1'b0;  // Logic clock.
  logic rst_b = 1'b0;  // Reset, active low.
  logic addr_pin = 1'b0;  // Address select level.
  logic sck, sel_b, sdi_w, dout_w, sdi_out, sdi_oe, dout_out, dout_oe;  // Pins.
  logic tick, three, spi_mode, flush, srst, ack;  // Status outputs.
  logic flush_seen = 1'b0, srst_seen = 1'b0;  // Sticky pulse records.
  logic [4:0] rate;  // Rate selector.
  logic [2:0] fcode;  // Filter code.
  logic [6:0] coef;  // Coefficient.
  logic [7:0] v, d;  // Received and sent bytes.
  int num_errors = 0, checked = 0, cycles = 0;  // Counters.
  assign dout_w = dout_oe ? dout_out : addr_pin;
  initial begin
    forever #2.5 clock = ~clock;
  end
  shp_host_port #(.BASE_CYCLES(BASE), .TRIM_SEED(SEED)) dut_u (.clock(clock), .rst_b(rst_b),
    .sck_pin(sck), .sdi_in(sdi_w), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
    .select_low_pin(sel_b), .addr_lsb_dout_in(dout_w), .addr_lsb_dout_out(dout_out),
    .addr_lsb_dout_oe(dout_oe), .rate_sel(rate), .sample_tick(tick), .filter_code(fcode),
    .iir_coef(coef), .three_wire_sel(three), .spi_mode(spi_mode), .fifo_flush(flush),
    .soft_reset(srst));
  shp_host_model host_u (.clock(clock), .sdi_oe(sdi_oe), .sdi_out(sdi_out), .dout_w(dout_w),
    .sck(sck), .sel_b(sel_b), .sdi_w(sdi_w));
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog and pulse recorders.
  always @(posedge clock) begin
    cycles++;
    if (flush === 1'b1) flush_seen <= 1'b1;
    if (srst === 1'b1) srst_seen <= 1'b1;
    if (cycles == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_rate(input logic [7:0] w);
    return (w[4:0] > 5'h11) ? 8'h11 : {3'h0, w[4:0]};
  endfunction
  function automatic logic [7:0] exp_coef(input logic [2:0] c);
    return (8'h01 << c) - 8'h01;
  endfunction
  task automatic spi_wr(input logic [7:0] a, input logic [7:0] w, input logic idle);
    host_u.spi_begin(idle);
    host_u.spi_byte({1'b0, a[6:0]}, v);
    host_u.spi_byte(w, v);
    host_u.spi_end(idle);
  endtask
  // Read with the dummy byte first, then two incrementing bytes.
  task automatic spi_rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    host_u.spi_begin(a[0]);
    host_u.spi_byte({1'b1, a[6:0]}, v);
    host_u.hrel = host_u.three;
    host_u.spi_byte(8'h00, v);
    check(v, 8'h00);
    host_u.spi_byte(8'h00, v);
    check(v, e0);
    host_u.spi_byte(8'h00, v);
    check(v, e1);
    host_u.spi_end(a[0]);
  endtask
  // Two address and data pairs in one transaction.
  task automatic i2c_wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] w,
                        input logic [7:0] a2, input logic [7:0] w2, input logic nak);
    host_u.i2c_start();
    host_u.i2c_byte(dev, ack);
    check({7'h0, ack}, {7'h0, nak});
    if (!nak) begin
      host_u.i2c_byte(a, ack);
      host_u.i2c_byte(w, ack);
      host_u.i2c_byte(a2, ack);
      host_u.i2c_byte(w2, ack);
      check({7'h0, ack}, 8'h00);
    end
    host_u.i2c_stop();
  endtask
  task automatic measure(input int exp);
    int n;
    n = 0;
    do begin @(posedge clock); #1; n++; end while (tick !== 1'b1 && n < 400);
    n = 0;
    do begin @(posedge clock); #1; n++; end while (tick !== 1'b1 && n < 400);
    check(n[7:0], exp[7:0]);
  endtask
  initial begin
    void'($urandom(30826));
    repeat (2) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clock);
    i2c_wr(8'hec, 8'h1d, 8'h03, 8'h1f, 8'h0a, 1'b0);
    check({3'h0, rate}, 8'h03);
    check({1'h0, coef}, 8'h1f);
    i2c_wr(8'hee, 8'h1d, 8'h07, 8'h1d, 8'h07, 1'b1);
    @(posedge clock);
    #1 addr_pin = 1'b1;
    i2c_wr(8'hee, 8'h1d, 8'h01, 8'h1d, 8'h01, 1'b0);
    check({3'h0, rate}, 8'h01);
    measure(BASE * 2);
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'h12 : (k == 1) ? 8'h11 : 8'($urandom);
      spi_wr(8'h1d, d, k[0]);
      check({3'h0, rate}, exp_rate(d));
    end
    check({7'h0, spi_mode}, 8'h01);
    i2c_wr(8'hee, 8'h1d, 8'h05, 8'h1d, 8'h05, 1'b1);
    for (int c = 0; c < 8; c++) begin
      d = 8'($urandom);
      d[3:1] = 3'(c);
      spi_wr(8'h1f, d, d[0]);
      check({5'h0, fcode}, 8'(c));
      check({1'h0, coef}, exp_coef(3'(c)));
    end
    spi_wr(8'h1d, 8'h02, 1'b1);
    spi_rd(8'h30, SEED ^ 8'h30, SEED ^ 8'h31);
    spi_rd(8'h1d, 8'h02, 8'h00);
    spi_wr(8'h7e, 8'h55, 1'b1);
    spi_rd(8'h7e, 8'h00, 8'h00);
    check({6'h0, flush_seen, srst_seen}, 8'h00);
    check({3'h0, rate}, 8'h02);
    spi_wr(8'h7e, 8'hb0, 1'b0);
    check({7'h0, flush_seen}, 8'h01);
    check({3'h0, rate}, 8'h02);
    spi_wr(8'h1a, 8'h01, 1'b1);
    check({7'h0, three}, 8'h01);
    host_u.three = 1'b1;
    spi_rd(8'h31, SEED ^ 8'h31, SEED ^ 8'h32);
    spi_wr(8'h1a, 8'h00, 1'b1);
    host_u.three = 1'b0;
    spi_wr(8'h1d, 8'h04, 1'b1);
    spi_wr(8'h7e, 8'hb6, 1'b1);
    check({7'h0, srst_seen}, 8'h01);
    check({3'h0, rate}, 8'h00);
    check({1'h0, coef}, 8'h00);
    check({7'h0, spi_mode}, 8'h01);
    tally_and_finish();
  end
endmodule
